// File: inc/sef_pkg.sv
`default_nettype none
package sef_pkg;

  // ************************************************************
  // array geometry
  // ************************************************************
  localparam int ADDR_W = 9;
  localparam int WORD_W = 16;
  localparam int WORDS = 512;
  localparam int FIFO_DEPTH = 16;
  localparam logic [WORD_W-1:0] BLANK_WORD = 16'hffff;

  // ************************************************************
  // instruction framing
  // ************************************************************
  localparam int OPC_W = 2;
  localparam int CNT_W = 5;
  localparam logic [OPC_W-1:0] OPC_READ_DFLT = 2'h2;
  localparam logic [OPC_W-1:0] OPC_WRITE_DFLT = 2'h1;
  localparam logic [CNT_W-1:0] OPC_LAST = 5'h01;
  localparam logic [CNT_W-1:0] ADDR_LAST = 5'h08;
  localparam logic [CNT_W-1:0] WORD_LAST = 5'h0f;
  localparam logic [CNT_W-1:0] WORD_FULL = 5'h10;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CORE_CLK_HZ = 10_000_000;
  localparam int WRITE_CYCLE_TIME_US = 10_000;
  localparam int WRITE_CYCLES_DFLT = WRITE_CYCLE_TIME_US * (CORE_CLK_HZ / 1_000_000);

  // ************************************************************
  // types
  // ************************************************************
  typedef struct packed {
    logic sel;
    logic clk;
    logic data;
  } sef_link_in_t;

  typedef enum logic [2:0] {
    ST_HUNT,
    ST_OPC,
    ST_ADDR,
    ST_READ,
    ST_WDATA,
    ST_SKIP
  } sef_state_t;

endpackage : sef_pkg
`default_nettype wire

// File: hw/sef_sync.sv
`default_nettype none
module sef_sync #(
  parameter int W = 3
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_reg;

  // ************************************************************
  // two-stage synchroniser
  // ************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_reg <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end

endmodule : sef_sync
`default_nettype wire

// File: hw/sef_fifo.sv
`default_nettype none
module sef_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem[rd_ptr_reg];

  // ************************************************************
  // storage
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data_i;
  end

  // ************************************************************
  // pointers and fill level
  // ************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else if (flush_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end

endmodule : sef_fifo
`default_nettype wire

// File: hw/sef_eeprom_rd.sv
// Summary of operation
// R1: with select high, serial data in is sampled on rising serial clock as start, opcode, address, data.
// R2: after select rises, the first rising clock that samples data high is the start bit; earlier lows are ignored. The code takes no start bit while busy.
// R3: the host ends each instruction by dropping select and holds it low for the deselect gap.
// R4: with select low the front end is in standby, ignores clock and data and takes no instruction.
// R5: on a read, the edge that samples the address lsb turns the output from floating to a low dummy bit.
// R6: after the dummy bit the addressed word's 16 bits go out msb first, one per rising clock.
// R7: while select stays high and clocking continues, the address advances and the next word streams out.
// R8: incrementing past the all-ones address wraps to address zero.
// R9: a blank array reads all ones in every word.
// R10: during completion checking the output is low while a write is busy and high once it is done.
// R11: a start bit sampled while the ready-high status shows floats the output at once.
// R12: the output floats whenever select is low and nothing is being presented.
// R13: a nine-bit word address counter, loaded from the address field, covers all 512 words.
`default_nettype none
module sef_eeprom_rd
  import sef_pkg::*;
#(
  parameter int WRITE_CYCLES = sef_pkg::WRITE_CYCLES_DFLT,
  parameter logic [sef_pkg::OPC_W-1:0] OPC_READ = sef_pkg::OPC_READ_DFLT,
  parameter logic [sef_pkg::OPC_W-1:0] OPC_WRITE = sef_pkg::OPC_WRITE_DFLT
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic CS_I,
  input wire logic SERIAL_CLOCK_IN_I,
  input wire logic SERIAL_DATA_IN_I,
  output logic DO_O,
  output logic DO_OE_O
);

  import sef_pkg::*;

  localparam int BW = $clog2(WRITE_CYCLES + 1);

  // ************************************************************
  // declarations
  // ************************************************************
  sef_link_in_t pins_raw;
  sef_link_in_t pins_s;
  logic [2:0] pins_vec;
  logic sclk_d_reg;
  logic cs_d_reg;
  logic active;
  logic sclk_rise;
  logic cs_fall;
  sef_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [OPC_W-1:0] opc_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;
  logic [ADDR_W-1:0] fill_addr_reg;
  logic [WORD_W-1:0] array_mem [WORDS];
  logic [WORD_W-1:0] wdata_reg;
  logic [CNT_W-1:0] wcnt_reg;
  logic [WORD_W-1:0] shift_reg;
  logic [CNT_W-1:0] bits_left_reg;
  logic [BW-1:0] busy_cnt_reg;
  logic busy;
  logic verify_reg;
  logic start_seen;
  logic addr_done;
  logic rd_start;
  logic wr_launch;
  logic fifo_flush;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [WORD_W-1:0] fifo_out_data;
  logic do_reg;
  logic oe_reg;

  // ************************************************************
  // pin sampling
  // ************************************************************
  assign pins_raw.sel = CS_I;
  assign pins_raw.clk = SERIAL_CLOCK_IN_I;
  assign pins_raw.data = SERIAL_DATA_IN_I;

  sef_sync #(
    .W(3)
  ) u_sync (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .async_i(pins_raw),
    .sync_o(pins_vec)
  );

  assign pins_s = sef_link_in_t'(pins_vec);

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      sclk_d_reg <= 1'b0;
      cs_d_reg <= 1'b0;
    end
    else
    begin
      sclk_d_reg <= pins_s.clk;
      cs_d_reg <= pins_s.sel;
    end
  end

  assign active = pins_s.sel;
  assign sclk_rise = active & pins_s.clk & ~sclk_d_reg; // R1
  assign cs_fall = cs_d_reg & ~pins_s.sel;
  assign busy = (busy_cnt_reg != '0);
  assign start_seen = sclk_rise & pins_s.data & (state_reg == ST_HUNT) & ~busy; // R2
  assign addr_next = {addr_reg[ADDR_W-2:0], pins_s.data};
  assign addr_done = sclk_rise & (state_reg == ST_ADDR) & (cnt_reg == ADDR_LAST);
  assign rd_start = addr_done & (opc_reg == OPC_READ); // R5
  assign wr_launch = cs_fall & (state_reg == ST_WDATA) & (wcnt_reg == WORD_FULL);

  // ************************************************************
  // instruction framing
  // ************************************************************
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state_reg <= ST_HUNT;
      cnt_reg <= '0;
      opc_reg <= '0;
      addr_reg <= '0;
    end
    else if (!active)
    begin
      state_reg <= ST_HUNT; // R4
      cnt_reg <= '0;
    end
    else if (sclk_rise)
    begin
      unique case (state_reg)
        ST_HUNT:
        begin
          if (start_seen)
          begin
            state_reg <= ST_OPC; // R2
            cnt_reg <= '0;
          end
        end
        ST_OPC:
        begin
          opc_reg <= {opc_reg[OPC_W-2:0], pins_s.data}; // R1
          if (cnt_reg == OPC_LAST)
          begin
            state_reg <= ST_ADDR;
            cnt_reg <= '0;
          end
          else
            cnt_reg <= cnt_reg + 1'b1;
        end
        ST_ADDR:
        begin
          addr_reg <= addr_next; // R1
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == ADDR_LAST)
          begin
            if (opc_reg == OPC_READ)
              state_reg <= ST_READ;
            else if (opc_reg == OPC_WRITE)
              state_reg <= ST_WDATA;
            else
              state_reg <= ST_SKIP;
          end
        end
        ST_READ, ST_WDATA, ST_SKIP:
        begin
          state_reg <= state_reg;
        end
      endcase
    end
  end

  // ************************************************************
  // word address counter
  // ************************************************************
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      fill_addr_reg <= '0;
    else if (rd_start)
      fill_addr_reg <= addr_next; // R13
    else if (fifo_in_valid && fifo_in_ready)
      fill_addr_reg <= fill_addr_reg + 1'b1; // R7 R8
  end

  // ************************************************************
  // memory array and write path
  // ************************************************************
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      for (int i = 0; i < WORDS; i++)
        array_mem[i] <= BLANK_WORD; // R9
    end
    else if (wr_launch)
      array_mem[addr_reg] <= wdata_reg;
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      wdata_reg <= '0;
      wcnt_reg <= '0;
    end
    else if (addr_done)
      wcnt_reg <= '0;
    else if (sclk_rise && state_reg == ST_WDATA)
    begin
      wdata_reg <= {wdata_reg[WORD_W-2:0], pins_s.data};
      if (wcnt_reg != WORD_FULL)
        wcnt_reg <= wcnt_reg + 1'b1;
    end
  end

  // ************************************************************
  // write completion status
  // ************************************************************
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      busy_cnt_reg <= '0;
    else if (wr_launch)
      busy_cnt_reg <= BW'(WRITE_CYCLES);
    else if (busy)
      busy_cnt_reg <= busy_cnt_reg - 1'b1;
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      verify_reg <= 1'b0;
    else if (wr_launch)
      verify_reg <= 1'b1;
    else if (start_seen)
      verify_reg <= 1'b0; // R11
  end

  // ************************************************************
  // read-ahead buffer
  // ************************************************************
  assign fifo_flush = ~active | rd_start;
  assign fifo_in_valid = (state_reg == ST_READ);
  assign fifo_pop = sclk_rise & (state_reg == ST_READ) & (bits_left_reg == '0) & fifo_out_valid;

  sef_fifo #(
    .W(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .flush_i(fifo_flush),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(array_mem[fill_addr_reg]),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );

  // ************************************************************
  // serial output
  // ************************************************************
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      do_reg <= 1'b0;
      oe_reg <= 1'b0;
      shift_reg <= '0;
      bits_left_reg <= '0;
    end
    else if (!active)
    begin
      oe_reg <= 1'b0; // R4 R12
      bits_left_reg <= '0;
    end
    else if (rd_start)
    begin
      oe_reg <= 1'b1; // R5
      do_reg <= 1'b0;
      bits_left_reg <= '0;
    end
    else if (state_reg == ST_READ)
    begin
      if (fifo_pop)
      begin
        do_reg <= fifo_out_data[WORD_W-1]; // R6 R7
        shift_reg <= {fifo_out_data[WORD_W-2:0], 1'b0};
        bits_left_reg <= WORD_LAST;
      end
      else if (sclk_rise && bits_left_reg != '0)
      begin
        do_reg <= shift_reg[WORD_W-1]; // R6
        shift_reg <= {shift_reg[WORD_W-2:0], 1'b0};
        bits_left_reg <= bits_left_reg - 1'b1;
      end
    end
    else if (state_reg == ST_HUNT && verify_reg && !start_seen)
    begin
      oe_reg <= 1'b1;
      do_reg <= ~busy; // R10
    end
    else
      oe_reg <= 1'b0; // R11 R12
  end

  assign DO_O = do_reg;
  assign DO_OE_O = oe_reg;

endmodule : sef_eeprom_rd
`default_nettype wire

// File: bench/sef_eeprom_rd_checker.sv
`default_nettype none
module sef_eeprom_rd_checker #(
  parameter int WRITE_CYCLES = 50
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic CS_I,
  input wire logic SERIAL_CLOCK_IN_I,
  input wire logic SERIAL_DATA_IN_I,
  input wire logic DO_O,
  input wire logic DO_OE_O
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LW = $clog2(WRITE_CYCLES + 2);
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  // ****
  // pin edge history
  // ****
  logic sclk_reg;
  logic cs_reg;
  logic [3:0] since_sclk_reg;
  logic [3:0] since_cs_reg;
  logic [4:0] rises_reg;
  logic [LW-1:0] busy_seen_reg;
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      sclk_reg <= 1'b0;
      cs_reg <= 1'b0;
      since_sclk_reg <= 4'hf;
      since_cs_reg <= 4'hf;
      rises_reg <= 5'h00;
    end
    else
    begin
      sclk_reg <= SERIAL_CLOCK_IN_I;
      cs_reg <= CS_I;
      since_sclk_reg <= (SERIAL_CLOCK_IN_I && !sclk_reg) ? 4'h0 :
        since_sclk_reg + {3'h0, since_sclk_reg != 4'hf};
      since_cs_reg <= (CS_I && !cs_reg) ? 4'h0 : since_cs_reg + {3'h0, since_cs_reg != 4'hf};
      rises_reg <= !CS_I ? 5'h00 :
        rises_reg + {4'h0, SERIAL_CLOCK_IN_I && !sclk_reg && rises_reg != 5'h1f};
    end
  end
  // busy status shown in one stretch
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      busy_seen_reg <= '0;
    else if (DO_OE_O && !DO_O && rises_reg == 5'h00)
      busy_seen_reg <= busy_seen_reg + LW'(busy_seen_reg != '1);
    else
      busy_seen_reg <= '0;
  end
  // ****
  // properties
  // ****
  sequence sel_idle;
    !CS_I [*6];
  endsequence
  sequence oe_on;
    $rose(DO_OE_O);
  endsequence
  sequence start_in_status;
    CS_I && SERIAL_CLOCK_IN_I && !sclk_reg && SERIAL_DATA_IN_I && rises_reg == 5'h00
      && DO_OE_O && DO_O;
  endsequence
  a_reset_quiet: assert property ($rose(RST_N_I) |-> !DO_OE_O && !DO_O)
    else $error("output active at reset release");
  a_standby_float: assert property (sel_idle |-> !DO_OE_O)
    else $error("output driven in standby");
  a_oe_rise_cause: assert property (oe_on |->
    CS_I && (since_sclk_reg inside {[1:7]} || since_cs_reg inside {[1:7]}))
    else $error("output enabled without cause");
  a_oe_fall_cause: assert property ($fell(DO_OE_O) |->
    !CS_I || since_sclk_reg inside {[1:7]})
    else $error("output floated without cause");
  a_dummy_low: assert property ($rose(DO_OE_O) && since_cs_reg > 4'h7 |-> !DO_O)
    else $error("read turn-on bit not low");
  a_frame_count: assert property ($rose(DO_OE_O) && since_cs_reg > 4'h7 |->
    rises_reg >= 5'h0c)
    else $error("read output before full frame");
  a_fall_on_sclk: assert property ($fell(DO_O) && DO_OE_O && $past(DO_OE_O) |->
    since_sclk_reg inside {[1:7]})
    else $error("data fell away from clock rise");
  a_rise_on_sclk: assert property ($rose(DO_O) && $past(DO_OE_O) && rises_reg > 5'h0c |->
    since_sclk_reg inside {[1:7]})
    else $error("data rose away from clock rise");
  a_start_floats: assert property (start_in_status |-> ##[1:6] !DO_OE_O)
    else $error("status not floated on start bit");
  a_busy_bounded: assert property (busy_seen_reg <= LW'(WRITE_CYCLES))
    else $error("busy status shown too long");
endmodule : sef_eeprom_rd_checker
`default_nettype wire

// File: bench/sef_host_model.sv
`default_nettype none
module sef_host_model (
  input wire logic clk_i,
  input wire logic do_i,
  input wire logic oe_i,
  output var sef_pkg::sef_link_in_t link_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import sef_pkg::*;
  // ****
  // host serial master
  // ****
  event seen_ev;
  logic [1:0] last_seen;
  initial
  begin
    link_o = '0;
    last_seen = 2'h0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_i);
  endtask : wait_n
  task automatic look();
    last_seen = {oe_i, do_i};
    -> seen_ev;
  endtask : look
  // clock stands low between frames
  task automatic sel(input logic v);
    link_o.clk = 1'b0;
    link_o.data = 1'b0;
    link_o.sel = v;
    wait_n(8);
  endtask : sel
  task automatic bit1(input logic d);
    link_o.clk = 1'b0;
    link_o.data = d;
    wait_n(4);
    look();
    link_o.clk = 1'b1;
    wait_n(4);
  endtask : bit1
endmodule : sef_host_model
`default_nettype wire

// File: bench/sef_eeprom_rd_tb.sv
`default_nettype none
module sef_eeprom_rd_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sef_pkg::*;
  // ****
  // clock, reset and wiring
  // ****
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  sef_link_in_t link;
  logic do_w;
  logic oe_w;
  logic [2:0] notes[$];
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [15:0] rnd = 16'h0028;
  logic [15:0] d1;
  logic [15:0] d2;
  always #50 core_clk = ~core_clk;
  sef_eeprom_rd #(.WRITE_CYCLES(50)) DUT (
    .CORE_CLK_I(core_clk), .RST_N_I(rst_n), .CS_I(link.sel), .SERIAL_CLOCK_IN_I(link.clk),
    .SERIAL_DATA_IN_I(link.data), .DO_O(do_w), .DO_OE_O(oe_w)
  );
  sef_host_model host (.clk_i(core_clk), .do_i(do_w), .oe_i(oe_w), .link_o(link));
  // ****
  // helpers, notes are {data checked, enable, data}
  // ****
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  task automatic one(input logic d, input logic [2:0] e);
    notes.push_back(e);
    host.bit1(d);
  endtask : one
  task automatic look(input logic [2:0] e);
    notes.push_back(e);
    host.look();
  endtask : look
  task automatic send(input logic [11:0] f, input logic [2:0] e0);
    for (int i = 11; i >= 0; i--)
      one(f[i], i == 11 ? e0 : 3'b000);
  endtask : send
  task automatic word(input logic [15:0] w, input logic rd);
    for (int i = 15; i >= 0; i--)
      one(rd ? rnd[i] : w[i], rd ? {2'h3, w[i]} : 3'h0);
  endtask : word
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  // ****
  // output watcher
  // ****
  initial
  begin
    logic [2:0] e;
    forever
    begin
      @(host.seen_ev);
      e = notes.size() ? notes.pop_front() : 3'bxxx;
      num_checks++;
      if (host.last_seen[1] !== e[1] || (e[2] === 1'b1 && host.last_seen[0] !== e[0]))
      begin
        miscompares++;
        $display("[ERR] oe,do expected %b seen %b", e[1:0], host.last_seen);
      end
    end
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      miscompares++;
      $display("[ERR] cycles expected below 4000 seen %0d", cycles);
      stop_test();
    end
  end
  // ****
  // tests
  // ****
  initial
  begin
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    host.wait_n(4);
    send({1'b1, OPC_READ_DFLT, rnd[8:0]}, 3'h0);
    host.sel(1'b0);
    $display("test standby done");
    host.sel(1'b1);
    repeat (3) one(1'b0, 3'b000);
    send({1'b1, OPC_READ_DFLT, 9'h005}, 3'b000);
    one(1'b0, 3'b110);
    word(BLANK_WORD, 1'b1);
    host.sel(1'b0);
    look(3'b000);
    $display("test blank read done");
    rnd = lfsr(rnd);
    d1 = rnd;
    rnd = lfsr(rnd);
    d2 = rnd;
    host.sel(1'b1);
    send({1'b1, OPC_WRITE_DFLT, 9'h1ff}, 3'b000);
    word(d1, 1'b0);
    host.sel(1'b0);
    host.sel(1'b1);
    look(3'b110);
    host.wait_n(60);
    look(3'b111);
    send({1'b1, OPC_WRITE_DFLT, 9'h000}, 3'b111);
    word(d2, 1'b0);
    host.sel(1'b0);
    host.sel(1'b1);
    host.wait_n(60);
    send({1'b1, OPC_READ_DFLT, 9'h1fe}, 3'b111);
    one(1'b0, 3'b110);
    word(BLANK_WORD, 1'b1);
    word(d1, 1'b1);
    word(d2, 1'b1);
    host.sel(1'b0);
    look(3'b000);
    $display("test write and stream done");
    host.sel(1'b1);
    send({1'b1, OPC_READ_DFLT, 9'h1ff}, 3'h0);
    one(rnd[0], 3'h6);
    rst_n = 1'b0;
    host.sel(1'b0);
    rst_n = 1'b1;
    look(3'h0);
    host.wait_n(4);
    host.sel(1'b1);
    send({1'b1, OPC_READ_DFLT, 9'h1ff}, 3'h0);
    one(rnd[1], 3'h6);
    word(BLANK_WORD, 1'b1);
    host.sel(1'b0);
    look(3'h0);
    $display("test mid-run reset done");
    host.wait_n(2);
    if (notes.size() != 0)
    begin
      miscompares++;
      $display("[ERR] notes left expected 0 seen %0d", notes.size());
    end
    stop_test();
  end
endmodule : sef_eeprom_rd_tb
bind sef_eeprom_rd sef_eeprom_rd_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .CS_I(CS_I),
  .SERIAL_CLOCK_IN_I(SERIAL_CLOCK_IN_I), .SERIAL_DATA_IN_I(SERIAL_DATA_IN_I),
  .DO_O(DO_O), .DO_OE_O(DO_OE_O)
);
`default_nettype wire
